// ===== rtl/ipvs_pkg.sv
// Shared constants and carrier types for the interrupt priority block.
package ipvs_pkg;

    // ==========================================================
    // Widths and counts
    localparam int NUM_SRC = 19;
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 16;
    localparam int PRIO_W  = 3;
    localparam int LVL_W   = 4;
    localparam int VEC_W   = 7;
    localparam int IDX_W   = 5;

    // ==========================================================
    // Register word addresses
    localparam logic [ADDR_W-1:0] REG_RTC  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CRC  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_LVD  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CTM  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SR3  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_MIX  = 4'h5;
    localparam logic [ADDR_W-1:0] REG_SPI  = 4'h6;
    localparam logic [ADDR_W-1:0] REG_CH9  = 4'h7;
    localparam logic [ADDR_W-1:0] REG_TEST = 4'h8;

    // ==========================================================
    // Priority codes
    localparam logic [PRIO_W-1:0] PRIO_OFF   = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_MIN   = 3'h1;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_MAX   = 3'h7;

    // ==========================================================
    // Test register layout
    localparam int TST_PEND_BIT = 15;
    localparam int TST_HOLD_BIT = 13;
    localparam int TST_LVL_LSB  = 8;
    localparam int TST_VEC_LSB  = 0;

    // Vector of source 0; the value is arbitrary, later sources follow.
    localparam logic [VEC_W-1:0] VEC_BASE = 7'h08;

    // ==========================================================
    // Source map, listed from source 18 down to source 0
    localparam logic [NUM_SRC-1:0][ADDR_W-1:0] SRC_REG = {
        REG_CH9, REG_CH9, REG_SPI, REG_SPI, REG_SPI, REG_SPI,
        REG_MIX, REG_MIX, REG_MIX, REG_MIX, REG_SR3, REG_SR3,
        REG_SR3, REG_CTM, REG_LVD, REG_CRC, REG_CRC, REG_CRC,
        REG_RTC};
    localparam logic [NUM_SRC-1:0][3:0] SRC_LSB = {
        4'h0, 4'h4, 4'h0, 4'h4, 4'h8, 4'hc,
        4'h0, 4'h4, 4'h8, 4'hc, 4'h4, 4'h8,
        4'hc, 4'h4, 4'h0, 4'h4, 4'h8, 4'hc,
        4'h8};

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ipvs_bus_req_t;

    typedef struct packed {
        logic              valid;
        logic [PRIO_W-1:0] prio;
        logic [VEC_W-1:0]  vector;
    } ipvs_cpu_req_t;

endpackage

// ===== rtl/ipvs_prio_field.sv
// One three-bit source priority field with its reset value.
`timescale 1ns/10ps
module ipvs_prio_field
    import ipvs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              wr_en,
    input  wire logic [PRIO_W-1:0] wr_val,
    output logic      [PRIO_W-1:0] prio
);

    typedef struct packed {
        logic [PRIO_W-1:0] prio;
        logic              written;
    } ipvs_field_st_t;

    ipvs_field_st_t st_ff;
    ipvs_field_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.prio    = wr_val;
            nxt_st.written = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{prio: PRIO_RESET, written: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prio = st_ff.prio;

    chk_reset_value: assert property (
        @(posedge clk) disable iff (!nrst)
        !st_ff.written |-> prio == PRIO_RESET)
        else $error("priority field left its reset value unwritten");

endmodule

// ===== rtl/ipvs_ack_capture.sv
// Holds the vector of the most recently acknowledged request.
`timescale 1ns/10ps
module ipvs_ack_capture
    import ipvs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ack,
    input  wire logic             req_valid,
    input  wire logic [VEC_W-1:0] req_vec,
    output logic      [VEC_W-1:0] last_vec
);

    typedef struct packed {
        logic [VEC_W-1:0] last_vec;
    } ipvs_cap_st_t;

    ipvs_cap_st_t st_ff;
    ipvs_cap_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // An acknowledge with nothing presented carries no vector.
        if (ack && req_valid) begin
            nxt_st.last_vec = req_vec;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign last_vec = st_ff.last_vec;

    chk_ack_capture: assert property (
        @(posedge clk) disable iff (!nrst)
        (ack && req_valid) |=> last_vec == $past(req_vec))
        else $error("acknowledged vector was not captured");

endmodule

// ===== rtl/ipvs_top.sv
// Priority fields, request arbitration and test register of the block.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module ipvs_top
    import ipvs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire ipvs_bus_req_t       bus,
    output logic      [DATA_W-1:0]   rdata,
    input  wire logic [NUM_SRC-1:0]  src_req,
    input  wire logic [LVL_W-1:0]    cpu_level,
    input  wire logic                irq_ack,
    output ipvs_cpu_req_t            irq
);

    // ==========================================================
    // State
    typedef struct packed {
        ipvs_cpu_req_t     irq;
        logic              hold;
        logic [DATA_W-1:0] rdata;
    } ipvs_top_st_t;

    ipvs_top_st_t st_ff;
    ipvs_top_st_t nxt_st;

    logic [NUM_SRC-1:0][PRIO_W-1:0] src_prio;
    logic [VEC_W-1:0]               last_vec;

    // ==========================================================
    // Priority fields
    // Each field owns only its three bits, so writes elsewhere in a
    // word fall on nothing and the unused positions stay zero.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_field
            logic              fld_wr;
            logic [PRIO_W-1:0] fld_val;

            assign fld_wr  = bus.wr && (bus.addr == SRC_REG[gi]);
            assign fld_val = bus.wdata[SRC_LSB[gi] +: PRIO_W];

            ipvs_prio_field u_field (
                .clk    (clk),
                .nrst   (nrst),
                .wr_en  (fld_wr),
                .wr_val (fld_val),
                .prio   (src_prio[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Arbitration
    // Ties go to the lowest source number, which keeps the choice
    // stable when several sources share a level.
    logic             best_v;
    logic [PRIO_W-1:0] best_p;
    logic [IDX_W-1:0] best_i;

    always_comb begin
        best_v = 1'b0;
        best_p = PRIO_OFF;
        best_i = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_req[i] && (src_prio[i] != PRIO_OFF) &&
                ({1'b0, src_prio[i]} > cpu_level) &&
                (src_prio[i] > best_p)) begin
                best_v = 1'b1;
                best_p = src_prio[i];
                best_i = IDX_W'(i);
            end
        end
    end

    // ==========================================================
    // Last acknowledged vector
    ipvs_ack_capture u_capture (
        .clk       (clk),
        .nrst      (nrst),
        .ack       (irq_ack),
        .req_valid (st_ff.irq.valid),
        .req_vec   (st_ff.irq.vector),
        .last_vec  (last_vec)
    );

    // ==========================================================
    // Read data
    logic [DATA_W-1:0] rd_val;

    always_comb begin
        rd_val = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (SRC_REG[i] == bus.addr) begin
                rd_val = rd_val | (DATA_W'(src_prio[i]) << SRC_LSB[i]);
            end
        end
        if (bus.addr == REG_TEST) begin
            rd_val[TST_PEND_BIT] = st_ff.irq.valid;
            rd_val[TST_HOLD_BIT] = st_ff.hold;
            rd_val[TST_LVL_LSB +: LVL_W] = cpu_level;
            rd_val[TST_VEC_LSB +: VEC_W] = st_ff.hold ? last_vec
                                         : st_ff.irq.vector;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        // The request drops for one cycle after an acknowledge so the
        // core can raise its level before the next pick is shown.
        nxt_st.irq.valid  = best_v && !irq_ack;
        nxt_st.irq.prio   = (best_v && !irq_ack) ? best_p : PRIO_OFF;
        nxt_st.irq.vector = (best_v && !irq_ack)
                          ? VEC_BASE + VEC_W'(best_i) : '0;
        if (bus.wr && (bus.addr == REG_TEST)) begin
            nxt_st.hold = bus.wdata[TST_HOLD_BIT];
        end
        nxt_st.rdata = bus.rd ? rd_val : '0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign irq   = st_ff.irq;
    assign rdata = st_ff.rdata;

    // ==========================================================
    // Checks
    logic any_top;
    logic all_off;

    always_comb begin
        any_top = 1'b0;
        all_off = 1'b1;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_req[i] && (src_prio[i] == PRIO_MAX)) begin
                any_top = 1'b1;
            end
            if (src_prio[i] != PRIO_OFF) begin
                all_off = 1'b0;
            end
        end
    end

    chk_top_wins: assert property (
        @(posedge clk) disable iff (!nrst)
        (any_top && (cpu_level < 4'h7) && !irq_ack)
        |=> irq.valid && (irq.prio == PRIO_MAX))
        else $error("priority seven source did not win");

    chk_above_level: assert property (
        @(posedge clk) disable iff (!nrst)
        irq.valid |-> ({1'b0, irq.prio} > $past(cpu_level)) &&
                      (irq.prio >= PRIO_MIN))
        else $error("request shown at or below core level");

    chk_disabled_quiet: assert property (
        @(posedge clk) disable iff (!nrst)
        all_off |=> !irq.valid)
        else $error("request raised with every source disabled");

    chk_unused_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.rd && (bus.addr == REG_RTC))
        |=> (rdata[15:11] == 5'h00) && (rdata[7:0] == 8'h00))
        else $error("unused calendar register bits read nonzero");

    chk_rtc_field: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.wr && (bus.addr == REG_RTC))
        ##1 (bus.rd && (bus.addr == REG_RTC))
        |=> rdata[10:8] == $past(bus.wdata[10:8], 2))
        else $error("calendar clock field did not read back");

    chk_supply_field: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.rd && (bus.addr == REG_LVD))
        |=> (rdata[15:3] == 13'h0000) &&
            (rdata[2:0] == $past(src_prio[4])))
        else $error("supply monitor register read wrong");

    chk_ch9_layout: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.rd && (bus.addr == REG_CH9))
        |=> (rdata[15:7] == 9'h000) && (rdata[3] == 1'b0) &&
            (rdata[6:4] == $past(src_prio[17])) &&
            (rdata[2:0] == $past(src_prio[18])))
        else $error("channel 9 register read wrong");

    chk_vector_shown: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.rd && (bus.addr == REG_TEST) && !st_ff.hold)
        |=> rdata[6:0] == $past(irq.vector))
        else $error("test register did not show pending vector");

    chk_pending_bit: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.rd && (bus.addr == REG_TEST))
        |=> rdata[15] == $past(irq.valid))
        else $error("pending bit does not follow the request");

    chk_level_report: assert property (
        @(posedge clk) disable iff (!nrst)
        (bus.rd && (bus.addr == REG_TEST))
        |=> rdata[11:8] == $past(cpu_level))
        else $error("core level field read wrong");

    chk_ack_drops: assert property (
        @(posedge clk) disable iff (!nrst)
        irq_ack |=> !irq.valid)
        else $error("request stayed up after acknowledge");

endmodule

// ===== bench/ipvs_cpu_model.sv
// Behavioural processor core that acknowledges presented requests.
`timescale 1ns/10ps
module ipvs_cpu_model
    import ipvs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire ipvs_cpu_req_t    irq,
    input  wire logic             ack_en,
    input  wire logic [3:0]       ack_wait,
    input  wire logic [LVL_W-1:0] lvl_set,
    output logic                  irq_ack,
    output logic      [LVL_W-1:0] cpu_level
);
    // ==========================================================
    // Acknowledge
    // The core acks only a standing request, ack_wait + 1 cycles after it is shown.
    logic [3:0] wait_ff;
    assign cpu_level = lvl_set;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_ff <= 4'h0;
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            if (ack_en && irq.valid && !irq_ack) begin
                wait_ff <= wait_ff + 4'h1;
                if (wait_ff >= ack_wait) begin
                    irq_ack <= 1'b1;
                    wait_ff <= 4'h0;
                end
            end
        end
    end
endmodule

// ===== bench/tb.sv
// Self-checking bench of the interrupt priority block.
`timescale 1ns/10ps
module tb
    import ipvs_pkg::*;
;
    // ==========================================================
    // Signals and shadow state
    logic               clk;
    logic               nrst;
    ipvs_bus_req_t      bus;
    logic [DATA_W-1:0]  rdata;
    logic [NUM_SRC-1:0] src_req;
    logic [LVL_W-1:0]   lvl_set;
    logic [LVL_W-1:0]   cpu_level;
    logic               irq_ack;
    logic               ack_en;
    logic [3:0]         ack_wait;
    ipvs_cpu_req_t      irq;
    int                 fail_count;
    int                 checks;
    integer             seed;
    logic [31:0]        r;
    logic [PRIO_W-1:0]  pr [NUM_SRC];
    // Upper nibble is the word address, lower nibble the field lsb.
    logic [7:0]         mp [NUM_SRC] = '{8'h08, 8'h1c, 8'h18, 8'h14,
        8'h20, 8'h34, 8'h4c, 8'h48, 8'h44, 8'h5c, 8'h58, 8'h54, 8'h50,
        8'h6c, 8'h68, 8'h64, 8'h60, 8'h74, 8'h70};

    ipvs_top u_ipvs_top (.clk(clk), .nrst(nrst), .bus(bus),
        .rdata(rdata), .src_req(src_req), .cpu_level(cpu_level),
        .irq_ack(irq_ack), .irq(irq));
    ipvs_cpu_model u_ipvs_cpu_model (.clk(clk), .nrst(nrst), .irq(irq),
        .ack_en(ack_en), .ack_wait(ack_wait), .lvl_set(lvl_set),
        .irq_ack(irq_ack), .cpu_level(cpu_level));

    always #50 clk = ~clk;

    // ==========================================================
    // Expectations
    function automatic logic [DATA_W-1:0] reg_exp(input logic [3:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (mp[i][7:4] == a) begin
                v = v | (DATA_W'(pr[i]) << mp[i][3:0]);
            end
        end
        return v;
    endfunction

    // Scanning downward with >= leaves the lowest index on a tie.
    function automatic ipvs_cpu_req_t win_exp(input logic [NUM_SRC-1:0] s,
                                              input logic [LVL_W-1:0] l);
        ipvs_cpu_req_t w;
        w = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (s[i] && pr[i] != 3'h0 && {1'b0, pr[i]} > l
                    && pr[i] >= w.prio) begin
                w = '{1'b1, pr[i], 7'h08 + 7'(i)};
            end
        end
        return w;
    endfunction

    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (mp[i][7:4] == a) begin
                pr[i] = d[mp[i][3:0] +: 3];
            end
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        bus <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        check(rdata, e);
    endtask

    task automatic arb();
        ipvs_cpu_req_t w;
        repeat (3) @(posedge clk);
        @(negedge clk);
        w = win_exp(src_req, lvl_set);
        check(16'(irq), 16'(w));
        rchk(REG_TEST, {w.valid, 3'h0, lvl_set, 1'b0, w.vector});
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        #2000000;
        fail_count++;
        end_of_test();
    end

    initial begin
        clk = 0;
        nrst = 0;
        bus = '0;
        src_req = '0;
        lvl_set = '0;
        ack_en = 0;
        ack_wait = 0;
        seed = 32'hd55f;
        fail_count = 0;
        checks = 0;
        for (int i = 0; i < NUM_SRC; i++) begin
            pr[i] = 3'h4;
        end
        repeat (4) @(posedge clk);
        nrst <= 1;
        for (int a = 0; a < 16; a++) begin
            rchk(4'(a), reg_exp(4'(a)));
        end
        for (int a = 0; a < 16; a++) begin
            wr(4'(a), 16'hffff);
            rchk(4'(a), a == 8 ? 16'h2000 : reg_exp(4'(a)));
        end
        wr(REG_TEST, 16'h0);
        // Corner cases: full tie, a disabled winner, a blocking level.
        for (int a = 0; a < 8; a++) begin
            wr(4'(a), 16'h7777);
        end
        src_req <= '1;
        arb();
        wr(REG_RTC, 16'h0);
        arb();
        lvl_set <= 4'h7;
        arb();
        for (int a = 0; a < 8; a++) begin
            wr(4'(a), 16'h1111);
        end
        lvl_set <= 4'h0;
        arb();
        for (int n = 0; n < 60; n++) begin
            r = $random(seed);
            wr(r[2:0], r[31:16]);
            rchk(r[2:0], reg_exp(r[2:0]));
            r = $random(seed);
            src_req <= r[18:0];
            lvl_set <= r[31] ? 4'h0 : r[30:27];
            arb();
        end
        // Acknowledge promptly, then slowly, and read the held vector.
        wr(REG_CTM, 16'h0030);
        lvl_set <= 4'h0;
        src_req <= 19'h00020;
        for (int k = 0; k < 2; k++) begin
            ack_wait <= 4'(k * 3);
            ack_en <= 1'b1;
            for (int t = 0; t < 20; t++) begin
                @(posedge clk);
                if (irq_ack === 1'b1) begin
                    break;
                end
            end
            ack_en <= 1'b0;
            @(negedge clk);
            check(16'(irq.valid), 16'h0);
            src_req <= 19'h00040;
            wr(REG_TEST, 16'h2000);
            rchk(REG_TEST, 16'ha00d);
            wr(REG_TEST, 16'h0);
            src_req <= 19'h00020;
        end
        end_of_test();
    end
endmodule
